// ==== rtl/sard_dev.sv ====
// Converter end: takes a code at frame start and shifts it out on the link.
// Assumes the link pins are asynchronous and are synchronised here.
`timescale 1ns/1ns
module sard_dev
  import sard_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  sard_if.dev LINK,
  input wire logic [11:0] SAMPLE_CODE,
  output logic BUSY
);
  // Link rules this block works to
  // - Host holds clock low when select falls
  // - Drive data after second falling clock edge
  // - Select high releases data three clocks later, after the select sync
  // - Frame sixteen cycles, short frame fourteen minimum
  // - Sample rate at most clock over sixteen
  // - Host may select less often
  // - Result shifted out most significant first
  // - Bits change on falling edges, null first
  // - Extra clocks repeat result lsb first
  // - Short frame fourteen or fifteen cycles
  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] sel_s;
    logic sck_d;
    logic [4:0] falls;
    logic [11:0] code;
    logic dout;
    logic oe;
    logic busy;
  } sard_dst_t;
  sard_dst_t s_r;
  sard_dst_t s_nxt;
  logic fall;
  logic sel_act;
  always_comb begin
    s_nxt = s_r;
    s_nxt.sck_s = {s_r.sck_s[0], LINK.sclk};
    s_nxt.sel_s = {s_r.sel_s[0], LINK.sel_n};
    s_nxt.sck_d = s_r.sck_s[1];
    fall = s_r.sck_d & ~s_r.sck_s[1];
    sel_act = ~s_r.sel_s[1];
    if (!sel_act) begin
      s_nxt.oe = 1'b0;
      s_nxt.falls = '0;
      s_nxt.busy = 1'b0;
    end else if (fall) begin
      // Clock is low at select, so the first edge seen is a rise and the first fall ends clock one
      if (s_r.falls != 5'h1f) begin
        s_nxt.falls = s_r.falls + 5'h01;
      end
      if (s_r.falls == 5'h00) begin
        s_nxt.code = SAMPLE_CODE;
        s_nxt.busy = 1'b1;
      end
      if (s_r.falls == 5'(SARD_EN_FALL - 1)) begin
        s_nxt.oe = 1'b1;
        s_nxt.dout = 1'b0;
      end else if (s_r.falls >= 5'(SARD_EN_FALL)
                   && s_r.falls < 5'(SARD_EN_FALL + SARD_BITS)) begin
        s_nxt.dout = s_r.code[4'(SARD_BITS + SARD_EN_FALL - 1) - 4'(s_r.falls)];
      end else if (s_r.falls >= 5'(SARD_EN_FALL + SARD_BITS)
                   && s_r.falls < 5'(SARD_EN_FALL + 2 * SARD_BITS - 1)) begin
        // LSB already went out last in the MSB pass, so resume at bit 1
        s_nxt.dout = s_r.code[4'(s_r.falls) - 4'(SARD_EN_FALL + SARD_BITS - 1)];
        s_nxt.busy = 1'b0;
      end else if (s_r.falls >= 5'(SARD_EN_FALL + 2 * SARD_BITS - 1)) begin
        s_nxt.dout = 1'b0;
      end
    end
    if (!NRST) begin
      s_nxt = '0;
      // Select sync starts at its idle level, so no false frame follows reset
      s_nxt.sel_s = 2'h3;
    end
  end
  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end
  assign LINK.dout = s_r.dout;
  assign LINK.dout_oe = s_r.oe;
  assign BUSY = s_r.busy;
endmodule : sard_dev

// ==== rtl/sard_fifo.sv ====
// FIFO: flip-flop storage with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sard_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sard_fifo

// ==== rtl/sard_host.sv ====
// Host end: makes the serial clock and select, captures codes into a FIFO.
// Assumes the converter end answers on the shared link interface.
`timescale 1ns/1ns
module sard_host
  import sard_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  sard_if.host LINK,
  input wire logic START,
  input wire logic [4:0] FRAME_LEN,
  output logic CODE_VALID,
  input wire logic CODE_READY,
  output logic [11:0] CODE,
  output logic ACTIVE
);
  typedef struct packed {
    sard_hstate_t st;
    logic [3:0] div;
    logic sclk;
    logic sel_n;
    logic [4:0] cyc;
    logic [4:0] len;
    logic [11:0] shf;
    logic [1:0] din_s;
    logic push;
    logic [4:0] gap;
    logic [1:0] cap;
  } sard_hst_t;
  sard_hst_t s_r;
  sard_hst_t s_nxt;
  logic f_ready;
  logic f_valid;
  logic [11:0] f_data;
  logic [4:0] want;
  always_comb begin
    s_nxt = s_r;
    s_nxt.push = 1'b0;
    // Released line reads low, like a pull-down
    s_nxt.din_s = {s_r.din_s[0], LINK.dout & LINK.dout_oe};
    want = (FRAME_LEN < 5'(SARD_SHORT_MIN_CYC)) ? 5'(SARD_SHORT_MIN_CYC) : FRAME_LEN;
    unique case (s_r.st)
      SARD_HS_IDLE: begin
        s_nxt.sclk = 1'b0;
        // Stall while the FIFO is full, so no code is dropped
        if (START && f_ready) begin
          s_nxt.sel_n = 1'b0;
          s_nxt.st = SARD_HS_RUN;
          s_nxt.div = '0;
          s_nxt.cyc = '0;
          s_nxt.len = want;
          s_nxt.cap = '0;
        end
      end
      SARD_HS_RUN: begin
        s_nxt.div = s_r.div + 4'h1;
        s_nxt.cap = {s_r.cap[0], 1'b0};
        // Two sync flops put the bit seen at each rise 2 cycles past the rise
        if (s_r.cap[1]) begin
          s_nxt.shf = {s_r.shf[10:0], s_r.din_s[1]};
          if (s_r.cyc == s_r.len) begin
            s_nxt.sel_n = 1'b1;
            s_nxt.st = SARD_HS_GAP;
            s_nxt.gap = SARD_GAP_CYC;
            s_nxt.push = 1'b1;
          end
        end
        if (s_r.div == SARD_DIV_HALF) begin
          s_nxt.div = '0;
          if (!s_r.sclk) begin
            s_nxt.cap[0] = 1'b1;
            // After the last fall the clock stays low and only the capture runs
            if (s_r.cyc != s_r.len) begin
              s_nxt.sclk = 1'b1;
            end
          end else begin
            s_nxt.sclk = 1'b0;
            s_nxt.cyc = s_r.cyc + 5'h01;
          end
        end
      end
      SARD_HS_GAP: begin
        s_nxt.gap = s_r.gap - 5'h01;
        if (s_r.gap == 5'h00) begin
          s_nxt.st = SARD_HS_IDLE;
        end
      end
      default: begin
        s_nxt.st = SARD_HS_IDLE;
      end
    endcase
    if (!NRST) begin
      s_nxt = '0;
      s_nxt.sel_n = 1'b1;
    end
  end
  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end
  assign LINK.sclk = s_r.sclk;
  assign LINK.sel_n = s_r.sel_n;
  assign ACTIVE = ~s_r.sel_n;
  sard_fifo #(.WIDTH(SARD_BITS), .DEPTH(SARD_FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .nrst(NRST),
    .in_valid(s_r.push),
    .in_ready(f_ready),
    .in_data(s_r.shf),
    .out_valid(f_valid),
    .out_ready(CODE_READY),
    .out_data(f_data)
  );
  assign CODE_VALID = f_valid;
  assign CODE = f_data;
endmodule : sard_host

// ==== rtl/sard_if.sv ====
// Interface: the serial link between converter and host.
// Assumes the host resolves the data wire from its output enable.
`timescale 1ns/1ns
interface sard_if;
  logic sclk;
  logic sel_n;
  logic dout;
  logic dout_oe;
  modport dev (input sclk, input sel_n, output dout, output dout_oe);
  modport host (output sclk, output sel_n, input dout, input dout_oe);
endinterface : sard_if

// ==== rtl/sard_pkg.sv ====
// Package: frame counts and shared types for the serial converter readout.
// Assumes both ends run on one system clock, CLK at 25 MHz.
package sard_pkg;
  localparam int unsigned SARD_BITS = 12;
  localparam int unsigned SARD_FRAME_CYC = 16;
  localparam int unsigned SARD_SHORT_MIN_CYC = 14;
  localparam int unsigned SARD_EN_FALL = 2;
  localparam int unsigned SARD_FIFO_DEPTH = 16;
  localparam int unsigned SARD_CLK_MHZ = 25;
  localparam int unsigned SARD_SCLK_DIV = 8;
  localparam logic [3:0] SARD_DIV_HALF = 4'h3;
  localparam logic [4:0] SARD_GAP_CYC = 5'h02;
  localparam logic [11:0] SARD_CODE_RESET = 12'h000;

  typedef enum logic [1:0] {
    SARD_HS_IDLE = 2'b00,
    SARD_HS_RUN = 2'b01,
    SARD_HS_GAP = 2'b10
  } sard_hstate_t;
endpackage : sard_pkg

// ==== verification/sar_adc_serial_readout_timing_tb.sv ====
// Testbench: host and converter ends joined by the link, codes read back.
// Assumes the host buffers 16 codes and reads last 12 sampled bits.
`timescale 1ns/1ns
module sar_adc_serial_readout_timing_tb;
  import sard_pkg::*;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic START = 1'b0;
  logic CODE_READY = 1'b0;
  logic [11:0] SAMPLE_CODE = 12'h000;
  logic [4:0] FRAME_LEN = 5'h0e;
  logic BUSY, CODE_VALID, ACTIVE;
  logic [11:0] CODE;
  logic [11:0] exp_q[$];
  int num_errors = 0;
  int checks = 0;
  sard_if link();
  sard_dev sard_dev_inst (.CLK(CLK), .NRST(NRST), .LINK(link.dev),
    .SAMPLE_CODE(SAMPLE_CODE), .BUSY(BUSY));
  sard_host sard_host_inst (.CLK(CLK), .NRST(NRST), .LINK(link.host), .START(START),
    .FRAME_LEN(FRAME_LEN), .CODE_VALID(CODE_VALID), .CODE_READY(CODE_READY),
    .CODE(CODE), .ACTIVE(ACTIVE));
  sard_props sard_props_inst (.CLK(CLK), .NRST(NRST), .sclk(link.sclk),
    .sel_n(link.sel_n), .dout(link.dout), .dout_oe(link.dout_oe));
  initial begin
    forever #20 CLK = ~CLK;
  end
  task close_out;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // A wait that runs out is a hang, so the run ends there
  task guard(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      close_out();
    end
  endtask : guard
  task frame(input logic [11:0] code, input logic [4:0] len);
    int n;
    int exp_n;
    logic busy_seen;
    logic [11:0] r;
    r = {<<{code}};
    // Short requests are stretched to the 14-cycle minimum
    exp_n = (len < 5'(SARD_SHORT_MIN_CYC) ? SARD_SHORT_MIN_CYC : int'(len)) * SARD_SCLK_DIV;
    // Select stays low half a period past the last fall, plus two cycles of capture lag
    exp_n = exp_n + SARD_SCLK_DIV / 2 + 2;
    SAMPLE_CODE = code;
    FRAME_LEN = len;
    START = 1'b1;
    n = 0;
    while (ACTIVE !== 1'b1 && n < 50) begin
      @(negedge CLK);
      n++;
    end
    guard(n, 50);
    START = 1'b0;
    busy_seen = 1'b0;
    n = 0;
    while (ACTIVE === 1'b1 && n < 300) begin
      if (BUSY === 1'b1) busy_seen = 1'b1;
      @(negedge CLK);
      n++;
    end
    guard(n, 300);
    chk("select low cycles", 12'(exp_n), 12'(n));
    chk("busy seen", 12'h001, {11'h000, busy_seen});
    exp_q.push_back(len == 5'h19 ? r : code);
  endtask : frame
  task pop(input logic [11:0] exp);
    int n;
    n = 0;
    while (CODE_VALID !== 1'b1 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    guard(n, 20);
    chk("code", exp, CODE);
    CODE_READY = 1'b1;
    @(negedge CLK);
    CODE_READY = 1'b0;
    // Let an edge pass so the ready strobe is never set twice in one step
    @(negedge CLK);
  endtask : pop
  initial begin
    repeat (12) @(negedge CLK);
    NRST = 1'b1;
    // Reader stalls while the buffer fills
    for (int i = 0; i < 16; i++) begin
      frame(12'(i) * 12'h123 ^ 12'ha5c, i == 5 ? 5'h19 : i == 9 ? 5'h0d : 5'h0e);
    end
    START = 1'b1;
    repeat (20) @(negedge CLK);
    chk("start when full", 12'h000, {11'h000, ACTIVE});
    START = 1'b0;
    for (int i = 0; i < 16; i++) pop(exp_q[i]);
    @(negedge CLK);
    chk("valid when empty", 12'h000, {11'h000, CODE_VALID});
    close_out();
  end
endmodule : sar_adc_serial_readout_timing_tb

// ==== verification/sard_props.sv ====
// Checker: timing relations on the link between converter and host ends.
// Assumes one clock CLK and a synchronous active-low NRST on both ends.
`timescale 1ns/1ns
module sard_props (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic dout,
  input wire logic dout_oe
);
  logic sel_q;
  logic sck_q;
  logic [4:0] nf;
  logic [7:0] lc;
  // Counts hold past the frame end so the end checks can read them
  always_ff @(posedge CLK) begin
    sel_q <= sel_n;
    sck_q <= sclk;
    if (!NRST) begin
      nf <= 5'h00;
      lc <= 8'h00;
    end else begin
      if (!sel_n && sel_q) nf <= 5'h00;
      else if (sck_q && !sclk) nf <= nf + 5'h01;
      if (!sel_n) lc <= sel_q ? 8'h01 : lc + 8'h01;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_sel_clk_low: assert property ($fell(sel_n) |-> !sclk)
    else $error("clock high at select");
  a_clk_idle: assert property (sel_n |-> !sclk)
    else $error("clock runs outside frame");
  a_oe_two_falls: assert property ($rose(dout_oe) |-> !sel_n && nf >= 5'h02)
    else $error("data enabled early");
  a_null_first: assert property ($rose(dout_oe) |-> !dout)
    else $error("leading bit not null");
  a_oe_release: assert property ($rose(sel_n) |-> ##[1:4] !dout_oe)
    else $error("data not released");
  a_oe_stays_off: assert property (sel_n [*5] |-> !dout_oe)
    else $error("data driven while idle");
  a_frame_falls: assert property ($rose(sel_n) |=> nf >= 5'h0e)
    else $error("frame too short");
  a_frame_cycles: assert property ($rose(sel_n) |-> lc >= 8'h70)
    else $error("select low too briefly");
  a_bit_stable: assert property (
    sclk && $past(sclk) && dout_oe && $past(dout_oe) |-> $stable(dout))
    else $error("data moved while clock high");
  cover property ($fell(sel_n));
  cover property ($rose(dout_oe));
  cover property ($rose(sel_n) ##1 nf > 5'h10);
endmodule : sard_props
